// ===== dv/reader_model.sv
`timescale 1ns/1ps
module reader_model
(
	input wire logic sys_clk,
	output tag_protect_pkg::cmd_type cmd,
	input wire tag_protect_pkg::resp_type resp
);
	import tag_protect_pkg::*;
	resp_type got;
	initial cmd = '0;
	// **********************************
	// One command frame and its answer
	// **********************************
	task automatic xfer(input logic [7:0] code, input logic [15:0] addr,
		input logic [7:0] data, input logic [1:0] pn, input logic pm);
	begin
		@(posedge sys_clk);
		#1;
		cmd = '{1'b1, code, addr, pn, data, pm};
		@(posedge sys_clk);
		#1;
		got = resp;
		// Idle fields scrambled so stale values never help
		cmd = '{1'b0, ~code, ~addr, ~pn, ~data, ~pm};
	end
	endtask : xfer
endmodule : reader_model

// ===== dv/tag_protect_tb.sv
`timescale 1ns/1ps
`include "tag_protect_defines.svh"
module tag_protect_tb;
	import tag_protect_pkg::*;
	logic sys_clk;
	logic reset;
	cmd_type cmd;
	resp_type resp;
	logic wen;
	logic [15:0] baddr;
	logic [7:0] fam;
	logic [7:0] fmt;
	logic [7:0] wc [2] = '{`CMD_WRITE_FAMILY, `CMD_WRITE_FORMAT};
	logic [7:0] lc [2] = '{`CMD_LOCK_FAMILY, `CMD_LOCK_FORMAT};
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	tag_protect tag_protect_i(.sys_clk(sys_clk), .reset(reset), .cmd(cmd),
		.resp(resp), .block_write_en(wen), .block_addr(baddr),
		.family_id(fam), .format_id(fmt));
	reader_model reader_model_i(.sys_clk(sys_clk), .cmd(cmd), .resp(resp));
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			stop_test();
		end
	end
	// **********************************
	// Access tasks
	// **********************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic op(input logic [7:0] code, input logic [15:0] addr,
		input logic [7:0] data, input logic e);
		reader_model_i.xfer(code, addr, data, 2'h0, 1'b0);
		check({reader_model_i.got.valid, reader_model_i.got.error},
			{1'b1, e});
	endtask : op
	task automatic pres(input logic [1:0] pn, input logic pm);
		reader_model_i.xfer(`CMD_PRESENT_PWD, 16'h0000, 8'h00, pn, pm);
	endtask : pres
	task automatic wcfg(input logic [7:0] idx, input logic [7:0] d,
		input logic e);
		op(`CMD_WRITE_CFG, {8'h00, idx}, d, e);
	endtask : wcfg
	task automatic rcfg(input logic [7:0] idx, input logic [7:0] exp);
		op(`CMD_READ_CFG, {8'h00, idx}, 8'h00, 1'b0);
		check(reader_model_i.got.data, exp);
	endtask : rcfg
	task automatic wblk(input logic [15:0] a, input logic e);
		op(`CMD_WRITE_BLOCK, a, 8'h00, e);
		check(wen, !e);
		check(baddr, a);
	endtask : wblk
	task automatic stat(input logic [15:0] a, input logic exp);
		op(`CMD_SEC_STATUS, a, 8'h00, 1'b0);
		check(reader_model_i.got.lock_bit, exp);
	endtask : stat
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// **********************************
	// Test sequence
	// **********************************
	initial
	begin
		reset = 1'b1;
		repeat (10) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		check(fam, 8'h00);
		check(fmt, 8'h00);
		rcfg(`CFG_MEM_SIZE_LO, 8'hff);
		rcfg(`CFG_MEM_SIZE_HI, 8'h01);
		rcfg(`CFG_BLOCK_BYTE_SIZE, 8'h03);
		rcfg(`CFG_CHIP_REF, `CHIP_REF_VALUE);
		wblk(16'h0002, 1'b0);
		$display("test reset_state done");
		wcfg(`CFG_AREA_SEC0, 8'h01, 1'b1);
		pres(2'h0, 1'b1);
		wcfg(`CFG_AREA_SEC0, 8'h03, 1'b0);
		pres(2'h1, 1'b1);
		wblk(16'h0002, 1'b1);
		op(`CMD_READ_BLOCK, 16'h0002, 8'h00, 1'b0);
		pres(2'h0, 1'b1);
		wcfg(`CFG_AREA_SEC0, 8'h05, 1'b0);
		wcfg(`CFG_AREA_END0, 8'h10, 1'b0);
		rcfg(`CFG_AREA_SEC0, 8'h05);
		rcfg(`CFG_AREA_END0, 8'h10);
		wcfg(8'h01, 8'h02, 1'b0);
		op(`CMD_READ_BLOCK, 16'h0220, 8'h00, 1'b1);
		stat(16'h0002, 1'b1);
		pres(2'h1, 1'b1);
		stat(16'h0002, 1'b0);
		wblk(16'h0002, 1'b0);
		wcfg(`CFG_AREA_SEC0, 8'h00, 1'b1);
		$display("test area_protect done");
		pres(2'h2, 1'b0);
		op(`CMD_WRITE_PWD, 16'h0000, 8'h33, 1'b1);
		op(`CMD_LOCK_BLOCK, 16'h0000, 8'h00, 1'b0);
		op(`CMD_READ_CFG, {8'h00, `CFG_HDR_LOCK}, 8'h00, 1'b1);
		wblk(16'h0000, 1'b1);
		stat(16'h0000, 1'b1);
		pres(2'h0, 1'b1);
		wcfg(`CFG_AREA_SEC0, 8'h00, 1'b0);
		wblk(16'h0000, 1'b1);
		wblk(16'h0001, 1'b0);
		$display("test block_lock done");
		wcfg(`CFG_LOCK_CFG, `LOCK_CFG_SET, 1'b0);
		rcfg(`CFG_LOCK_CFG, `LOCK_CFG_SET);
		wcfg(`CFG_AREA_SEC0, 8'h05, 1'b1);
		pres(2'h0, 1'b1);
		wcfg(`CFG_AREA_SEC0, 8'h05, 1'b1);
		rcfg(`CFG_AREA_SEC0, 8'h00);
		op(`CMD_WRITE_PWD, 16'h0000, 8'h33, 1'b0);
		op(`CMD_LOCK_BLOCK, 16'h0001, 8'h00, 1'b0);
		wblk(16'h0001, 1'b1);
		$display("test config_lock done");
		for (int i = 0; i < 2; i++)
		begin
			op(wc[i], 16'h0000, 8'h5a, 1'b0);
			op(lc[i], 16'h0000, 8'h00, 1'b0);
			op(wc[i], 16'h0000, 8'h11, 1'b1);
			op(lc[i], 16'h0000, 8'h00, 1'b1);
		end
		check(fam, 8'h5a);
		check(fmt, 8'h5a);
		rcfg(`CFG_FORMAT_ID, 8'h5a);
		rcfg(`CFG_FAMILY_ID, 8'h5a);
		op(`CMD_READ_CFG, {8'h00, `CFG_FAMILY_LOCK}, 8'h00, 1'b1);
		$display("test id_lock done");
		stop_test();
	end
endmodule : tag_protect_tb

// ===== logic/tag_protect.sv
`timescale 1ns/1ps
// Operation
// - Factory state leaves every user area unprotected for read and write.
// - Reads of area one are always allowed.
// - Area security selects password 1-3; selector zero opens no session.
// - New area protection applies as soon as its write completes.
// - Blocks 0 and 1 are lockable separately; locks never clear.
// - Locking block 0 or 1 sets its header lock bit.
// - Block 0/1 locking needs no password, ignores config and area locks.
// - Unprotecting area one does not release locked blocks 0 and 1.
// - Changing area ends leaves area security registers unchanged.
// - Security status and option reads report lock bit for write protection.
// - Reported lock bit follows the current session state.
// - Config writes need open config session and lock register 00h.
// - Config reads allowed except header, format and family lock registers.
// - Writing 01h to config lock blocks config writes forever.
// - Passwords remain changeable while configuration is locked.
// - Family and format ids lock separately and permanently.
// - Config lock does not lock family or format identifiers.
// - Id lock uses bit 0, upper bits zero, writable only unlocked.
// - Format id resets 00h, always readable, writable only unlocked.
// - Family id resets 00h, always readable, writable only unlocked.
// - Memory size in blocks is read-only, low byte first.
// - Block size byte reads 03h, meaning four bytes per block.
// - Any new password presentation closes the previous session.
`include "tag_protect_defines.svh"

module tag_protect
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire tag_protect_pkg::cmd_type cmd,
	output tag_protect_pkg::resp_type resp,
	output logic block_write_en,
	output logic [15:0] block_addr,
	output logic [7:0] family_id,
	output logic [7:0] format_id
);
	import tag_protect_pkg::*;

	// ******************************
	// Registers
	// ******************************
	logic [7:0] area_security_register [4];
	logic [7:0] area_end_pointer [3];
	logic [7:0] lock_cfg;
	logic [1:0] header_block_lock;
	logic format_id_lock;
	logic family_id_lock;
	logic [1:0] session_pwd;
	session_type session;
	logic [7:0] cfg_index;

	assign cfg_index = cmd.addr[7:0];

	// ******************************
	// Decode helpers
	// ******************************
	function automatic logic [1:0] area_of(input logic [15:0] addr,
		input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] e2);
		logic [7:0] blk_hi;
		blk_hi = addr[12:5];
		if (blk_hi <= e0)
			area_of = 2'd0;
		else if (blk_hi <= e1)
			area_of = 2'd1;
		else if (blk_hi <= e2)
			area_of = 2'd2;
		else
			area_of = 2'd3;
	endfunction : area_of

	function automatic logic area_open(input logic [7:0] sec,
		input session_type s, input logic [1:0] pwd);
		area_open = (s == sess_user) && (sec[3:2] != 2'b00)
			&& (sec[3:2] == pwd);
	endfunction : area_open

	logic [1:0] cur_area;
	logic [7:0] cur_sec;
	logic user_open;
	logic write_prot;
	logic read_prot;
	logic cfg_write_ok;
	logic cfg_readable;

	always_comb
	begin
		cur_area = area_of(cmd.addr, area_end_pointer[0],
			area_end_pointer[1], area_end_pointer[2]);
		cur_sec = area_security_register[cur_area];
		user_open = area_open(cur_sec, session, session_pwd);
		// Effective protection follows session right now
		write_prot = (cur_sec[`SEC_WRITE_BIT] && !user_open)
			|| (cmd.addr[15:1] == 15'h0000
			&& header_block_lock[cmd.addr[0]]);
		read_prot = cur_sec[`SEC_READ_BIT] && !user_open
			&& (cur_area != 2'd0);
		cfg_write_ok = (session == sess_config)
			&& (lock_cfg == `LOCK_CFG_OPEN);
		cfg_readable = !(cfg_index == `CFG_HDR_LOCK
			|| cfg_index == `CFG_FORMAT_LOCK
			|| cfg_index == `CFG_FAMILY_LOCK);
	end

	// ******************************
	// Sessions
	// ******************************
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			session <= sess_none;
			session_pwd <= 2'b00;
		end
		else if (cmd.valid && cmd.code == `CMD_PRESENT_PWD)
		begin
			session_pwd <= cmd.pwd_num;
			if (!cmd.pwd_match)
				session <= sess_none;
			else if (cmd.pwd_num == 2'd0)
				session <= sess_config;
			else
				session <= sess_user;
		end
	end

	// ******************************
	// Area security and bounds
	// ******************************
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_sec
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					area_security_register[gi] <= `RST_BYTE;
				else if (cmd.valid && cmd.code == `CMD_WRITE_CFG
					&& cfg_write_ok
					&& cfg_index == `CFG_AREA_SEC0 + 8'(gi))
					area_security_register[gi] <= cmd.data;
			end
		end
		for (gi = 0; gi < 3; gi++)
		begin : g_end
			always_ff @(posedge sys_clk)
			begin
				if (reset)
					area_end_pointer[gi] <= `RST_AREA_END;
				else if (cmd.valid && cmd.code == `CMD_WRITE_CFG
					&& cfg_write_ok
					&& cfg_index == `CFG_AREA_END0 + 8'(gi))
					area_end_pointer[gi] <= cmd.data;
			end
		end
	endgenerate

	// ******************************
	// Configuration lock
	// ******************************
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			lock_cfg <= `LOCK_CFG_OPEN;
		else if (cmd.valid && cmd.code == `CMD_WRITE_CFG && cfg_write_ok
			&& cfg_index == `CFG_LOCK_CFG
			&& cmd.data == `LOCK_CFG_SET)
			lock_cfg <= `LOCK_CFG_SET;
	end

	// ******************************
	// Header block locks
	// ******************************
	always_ff @(posedge sys_clk)
	begin
		if (reset)
			header_block_lock <= 2'b00;
		else if (cmd.valid && cmd.code == `CMD_LOCK_BLOCK
			&& cmd.addr[15:1] == 15'h0000)
			header_block_lock[cmd.addr[0]] <= 1'b1;
	end

	// ******************************
	// Identifiers
	// ******************************
	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			family_id_lock <= 1'b0;
			format_id_lock <= 1'b0;
		end
		else if (cmd.valid)
		begin
			if (cmd.code == `CMD_LOCK_FAMILY)
				family_id_lock <= 1'b1;
			if (cmd.code == `CMD_LOCK_FORMAT)
				format_id_lock <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			family_id <= `RST_BYTE;
			format_id <= `RST_BYTE;
		end
		else if (cmd.valid)
		begin
			if (cmd.code == `CMD_WRITE_FAMILY && !family_id_lock)
				family_id <= cmd.data;
			if (cmd.code == `CMD_WRITE_FORMAT && !format_id_lock)
				format_id <= cmd.data;
		end
	end

	// ******************************
	// Responses
	// ******************************
	resp_type next_resp;
	logic next_write_en;

	always_comb
	begin
		next_resp = '0;
		next_write_en = 1'b0;
		next_resp.valid = cmd.valid;
		unique case (cmd.code)
			`CMD_WRITE_BLOCK:
			begin
				next_resp.error = write_prot;
				next_write_en = cmd.valid && !write_prot;
			end
			`CMD_READ_BLOCK:
			begin
				next_resp.error = read_prot;
				next_resp.lock_bit = write_prot;
			end
			`CMD_SEC_STATUS:
				next_resp.lock_bit = write_prot;
			`CMD_WRITE_CFG:
				next_resp.error = !cfg_write_ok;
			`CMD_WRITE_PWD:
				// Password change is not gated by config lock
				next_resp.error = !((session == sess_config
					&& cmd.pwd_num == 2'd0) || (session == sess_user
					&& cmd.pwd_num == session_pwd && cmd.pwd_num != 2'd0));
			`CMD_WRITE_FAMILY:
				next_resp.error = family_id_lock;
			`CMD_WRITE_FORMAT:
				next_resp.error = format_id_lock;
			`CMD_LOCK_FAMILY:
				next_resp.error = family_id_lock;
			`CMD_LOCK_FORMAT:
				next_resp.error = format_id_lock;
			`CMD_LOCK_BLOCK:
				next_resp.error = (cmd.addr[15:1] != 15'h0000)
					&& write_prot;
			`CMD_READ_CFG:
			begin
				next_resp.error = !cfg_readable;
				if (cfg_index == `CFG_MEM_SIZE_LO)
					next_resp.data = 8'(`MEM_BLOCKS);
				else if (cfg_index == `CFG_MEM_SIZE_HI)
					next_resp.data = 8'(`MEM_BLOCKS >> 8);
				else if (cfg_index == `CFG_BLOCK_BYTE_SIZE)
					next_resp.data = `BLOCK_SIZE_CODE;
				else if (cfg_index == `CFG_CHIP_REF)
					next_resp.data = `CHIP_REF_VALUE;
				else if (cfg_index == `CFG_FORMAT_ID)
					next_resp.data = format_id;
				else if (cfg_index == `CFG_FAMILY_ID)
					next_resp.data = family_id;
				else if (cfg_index == `CFG_LOCK_CFG)
					next_resp.data = lock_cfg;
				else if (cfg_index < `CFG_AREA_END0)
					next_resp.data = area_security_register[cfg_index[1:0]];
				else if (cfg_index < `CFG_AREA_END0 + 8'h03)
					next_resp.data = area_end_pointer[cfg_index[1:0]];
			end
			default:
				next_resp.data = `RST_BYTE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (reset)
		begin
			resp <= '0;
			block_write_en <= 1'b0;
			block_addr <= 16'h0000;
		end
		else
		begin
			resp <= next_resp;
			block_write_en <= next_write_en;
			block_addr <= cmd.addr;
		end
	end

	// ******************************
	// Checks
	// ******************************
	hdr_lock_sticky_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		header_block_lock[0] |=> header_block_lock[0])
		else $error("header lock 0 cleared");
	hdr_lock_one_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		header_block_lock[1] |=> header_block_lock[1])
		else $error("header lock 1 cleared");
	hdr_lock_set_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_LOCK_BLOCK && cmd.addr == 16'h0001
		|=> header_block_lock[1])
		else $error("header lock 1 not set");
	locked_blk_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_WRITE_BLOCK && cmd.addr == 16'h0000
		&& header_block_lock[0] |=> !block_write_en && resp.error)
		else $error("locked block written");
	blk_lock_free_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_LOCK_BLOCK
		&& cmd.addr[15:1] == 15'h0000 |=> resp.valid && !resp.error)
		else $error("header block lock refused");
	sec_status_lock_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_SEC_STATUS && cmd.addr == 16'h0000
		&& header_block_lock[0] |=> resp.lock_bit)
		else $error("locked block reported open");
	cfg_lock_perm_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		lock_cfg == `LOCK_CFG_SET |=> lock_cfg == `LOCK_CFG_SET)
		else $error("config lock released");
	cfg_guard_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		lock_cfg == `LOCK_CFG_SET |=> $stable(area_security_register[0]))
		else $error("config written while locked");
	cfg_refused_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_WRITE_CFG && lock_cfg == `LOCK_CFG_SET
		|=> resp.error)
		else $error("locked config write accepted");
	pwd_change_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_WRITE_PWD && session == sess_config
		&& cmd.pwd_num == 2'd0 |=> !resp.error)
		else $error("password change refused");
	hdr_read_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_READ_CFG && cfg_index == `CFG_HDR_LOCK
		|=> resp.error)
		else $error("header lock read allowed");
	block_byte_size_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_READ_CFG && cfg_index == `CFG_BLOCK_BYTE_SIZE
		|=> resp.data == `BLOCK_SIZE_CODE)
		else $error("block size value wrong");
	family_guard_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		family_id_lock |=> $stable(family_id))
		else $error("family id written while locked");
	family_lock_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		family_id_lock |=> family_id_lock)
		else $error("family lock released");
	format_guard_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		format_id_lock |=> $stable(format_id) && format_id_lock)
		else $error("format id written while locked");
	area1_read_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_READ_BLOCK && cur_area == 2'd0
		|=> resp.valid && !resp.error)
		else $error("area one read refused");
	session_close_a: assert property (@(posedge sys_clk)
		disable iff (reset)
		cmd.valid && cmd.code == `CMD_PRESENT_PWD && !cmd.pwd_match
		|=> session == sess_none)
		else $error("session not closed");
endmodule : tag_protect

// ===== pkg/tag_protect_defines.svh
`ifndef TAG_PROTECT_DEFINES_SVH
`define TAG_PROTECT_DEFINES_SVH

// Command codes
`define CMD_WRITE_FAMILY 8'h27
`define CMD_LOCK_FAMILY 8'h28
`define CMD_WRITE_FORMAT 8'h29
`define CMD_LOCK_FORMAT 8'h2a
`define CMD_LOCK_BLOCK 8'h22
`define CMD_WRITE_BLOCK 8'h21
`define CMD_READ_BLOCK 8'h20
`define CMD_SEC_STATUS 8'h2c
`define CMD_PRESENT_PWD 8'hb3
`define CMD_WRITE_PWD 8'hb1
`define CMD_WRITE_CFG 8'ha1
`define CMD_READ_CFG 8'ha0

// Configuration register indexes
`define CFG_AREA_SEC0 8'h00
`define CFG_AREA_END0 8'h04
`define CFG_LOCK_CFG 8'h0f
`define CFG_HDR_LOCK 8'h10
`define CFG_FORMAT_LOCK 8'h11
`define CFG_FAMILY_LOCK 8'h12
`define CFG_MEM_SIZE_LO 8'h13
`define CFG_MEM_SIZE_HI 8'h14
`define CFG_BLOCK_BYTE_SIZE 8'h15
`define CFG_CHIP_REF 8'h16
`define CFG_FORMAT_ID 8'h17
`define CFG_FAMILY_ID 8'h18

// Area security fields
`define SEC_WRITE_BIT 0
`define SEC_READ_BIT 1
`define SEC_PWD_LSB 2

// Reset and fixed values
`define RST_BYTE 8'h00
`define RST_AREA_END 8'hff
`define MEM_BLOCKS 16'h01ff
`define BLOCK_SIZE_CODE 8'h03
// Arbitrary chip reference, names no real part
`define CHIP_REF_VALUE 8'h5a
`define LOCK_CFG_SET 8'h01
`define LOCK_CFG_OPEN 8'h00

`endif

// ===== pkg/tag_protect_pkg.sv
package tag_protect_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [15:0] addr;
		logic [1:0] pwd_num;
		logic [7:0] data;
		logic pwd_match;
	} cmd_type;

	typedef struct packed {
		logic valid;
		logic error;
		logic [7:0] data;
		logic lock_bit;
	} resp_type;

	typedef enum logic [1:0] {
		sess_none = 2'b00,
		sess_user = 2'b01,
		sess_config = 2'b10
	} session_type;
endpackage : tag_protect_pkg
